// File: hdl/tws_pkg.sv
package tws_pkg;
	// Core clock period; the bus-timing cycle counts below are derived from it.
	localparam int CLK_NS = 8;

	// Address byte layout: fixed upper nibble, three select bits, direction.
	localparam int            ADDR_HI_MSB = 7;
	localparam int            ADDR_HI_LSB = 4;
	localparam int            SEL_MSB     = 3;
	localparam int            SEL_LSB     = 1;
	localparam int            RW_BIT      = 0;
	localparam logic [3:0]    ADDR_FIXED  = 4'he;
	localparam logic [2:0]    SEL_VAR_A   = 3'h0;
	localparam logic [2:0]    SEL_VAR_B   = 3'h1;
	localparam logic [2:0]    SEL_VAR_C   = 3'h2;
	// Select code on which every sensor answers at once.
	localparam logic [2:0]    SEL_GROUP   = 3'h7;
	localparam int            MAX_DEVICES = 3;

	// Bit counting within a byte plus its acknowledge slot.
	localparam logic [3:0]    BIT_LAST    = 4'h7;
	localparam logic [3:0]    BIT_ACK     = 4'h8;
	localparam logic [7:0]    PTR_RESET   = 8'h00;
	localparam logic [7:0]    BYTE_ZERO   = 8'h00;

	// Temperature code weight in micro degrees Celsius per LSB.
	localparam int            TEMP_LSB_UC = 62500;

	// Glitch filter: a line must hold a new level this many cycles.
	localparam logic [1:0]    FILT_LEN    = 2'h3;

	// Fast-mode bus timing in ns; least times round up to cycles.
	localparam int T_LOW_NS   = 1300;
	localparam int T_HIGH_NS  = 600;
	localparam int T_HDSTA_NS = 100;
	localparam int T_SUSTA_NS = 100;
	localparam int T_SUSTO_NS = 100;
	localparam int T_BUF_NS   = 600;
	localparam logic [7:0] CYC_LOW_HALF = 8'((T_LOW_NS / 2 + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] CYC_HIGH     = 8'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] CYC_HDSTA    = 8'((T_HDSTA_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] CYC_SUSTA    = 8'((T_SUSTA_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] CYC_SUSTO    = 8'((T_SUSTO_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] CYC_BUF      = 8'((T_BUF_NS + CLK_NS - 1) / CLK_NS);

	// Byte-level commands accepted by the master end.
	typedef enum logic [1:0] {
		CMD_START,
		CMD_STOP,
		CMD_WRITE,
		CMD_READ
	} tws_cmd_t;
endpackage

// File: hdl/tws_bus_if.sv
`timescale 1ns/1ps
// Open-drain bus: a line is low while any party enables its driver.
interface tws_bus_if;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic s_sda_out;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Pull-ups are modelled as a released line reading high.
	assign scl = m_scl_oe ? m_scl_out : 1'b1;
	assign sda = (m_sda_oe ? m_sda_out : 1'b1) & (s_sda_oe ? s_sda_out : 1'b1);

	modport host (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
	modport dev (output s_sda_out, s_sda_oe, input scl, sda);
endinterface

// File: hdl/tws_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser and glitch filter for the clock and data lines.
module tws_sync
	import tws_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] line_i,
	output logic      [1:0] line_o
);
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_line
			logic       meta_r;
			logic       sync_r;
			logic       filt_r;
			logic       filt_nxt;
			logic [1:0] cnt_r;
			logic [1:0] cnt_nxt;

			// A new level is taken only after it held for the filter length.
			always_comb begin
				filt_nxt = filt_r;
				cnt_nxt  = 2'h0;
				if (sync_r != filt_r) begin
					cnt_nxt = cnt_r + 2'h1;
					if (cnt_nxt == FILT_LEN) begin
						filt_nxt = sync_r;
						cnt_nxt  = 2'h0;
					end
				end
			end

			// Lines idle high, so the chain resets high to avoid a false edge.
			always_ff @(posedge clock_i or posedge rst_i) begin
				if (rst_i) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
					filt_r <= 1'b1;
					cnt_r  <= 2'h0;
				end else begin
					meta_r <= line_i[g];
					sync_r <= meta_r;
					filt_r <= filt_nxt;
					cnt_r  <= cnt_nxt;
				end
			end
			assign line_o[g] = filt_r;
		end
	endgenerate
endmodule

// File: hdl/tws_dev.sv
`timescale 1ns/1ps
// Summary of operation
// - Both lines high means idle bus.
// - Data falling while clock high is START.
// - Master opens each transaction with START.
// - Data rising while clock high is STOP; release.
// - Master closes each transaction with STOP.
// - Master alone chooses the byte count.
// - Receiver holds data low through ninth pulse.
// - Master not-acknowledge ends slave transmission.
// - Address byte: fixed nibble, select, direction.
// - Select bits are a build-time constant.
// - Every addressed sensor acknowledges each byte.
// - Master acknowledges each read byte to continue.
// - Up to three sensors, distinct addresses.
// - Group address lets all sensors answer together.
// - Registers move one byte at a time.
// - Clock from 1 kHz to 400 kHz/3.4 MHz.
// - Temperature code weighs 0.0625 degrees per LSB.
// - Bytes travel most significant bit first.
// - Master sends pointer byte after write address.
// - Pointer is kept until reset or rewrite.
// - Master keeps data stable while clock high.
module tws_dev
	import tws_pkg::*;
#(
	parameter logic [2:0] SEL_CODE = SEL_VAR_A
)(
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	tws_bus_if.dev          bus,
	input  wire logic [7:0] rd_data_i,
	output logic      [7:0] ptr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_stb_o,
	output logic            rd_stb_o,
	output logic            group_o
);
	typedef enum logic [2:0] {
		DS_IDLE,
		DS_ADDR,
		DS_ACK,
		DS_RX,
		DS_TX,
		DS_TXACK,
		DS_IGNORE
	} tws_dev_st_t;

	logic [1:0]  line_f;
	logic        scl_q_r;
	logic        sda_q_r;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_ev;
	logic        stop_ev;
	logic        match;
	logic        grp_hit;
	tws_dev_st_t st_r;
	tws_dev_st_t st_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	logic [7:0]  sh_r;
	logic [7:0]  sh_nxt;
	logic        oe_r;
	logic        oe_nxt;
	logic        rw_r;
	logic        rw_nxt;
	logic        first_r;
	logic        first_nxt;
	logic [7:0]  ptr_r;
	logic [7:0]  ptr_nxt;
	logic [7:0]  wdata_r;
	logic [7:0]  wdata_nxt;
	logic        wr_stb_r;
	logic        wr_stb_nxt;
	logic        rd_stb_r;
	logic        rd_stb_nxt;
	logic        grp_r;
	logic        grp_nxt;

	// Both lines pass two flops and a glitch filter before any edge logic.
	tws_sync u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.line_i  ({bus.scl, bus.sda}),
		.line_o  (line_f)
	);

	// Previous filtered levels give the edges; the filter delays both lines
	// alike, so their order survives as long as it exceeds one cycle.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= line_f[1];
			sda_q_r <= line_f[0];
		end
	end

	// Edge and condition decode.
	assign scl_rise = line_f[1] & ~scl_q_r;
	assign scl_fall = ~line_f[1] & scl_q_r;
	assign start_ev = line_f[1] & scl_q_r & sda_q_r & ~line_f[0];
	assign stop_ev  = line_f[1] & scl_q_r & ~sda_q_r & line_f[0];

	// Own select is a constant; the group code reaches every variant.
	assign grp_hit = (sh_r[SEL_MSB:SEL_LSB] == SEL_GROUP);
	assign match   = (sh_r[ADDR_HI_MSB:ADDR_HI_LSB] == ADDR_FIXED)
		&& ((sh_r[SEL_MSB:SEL_LSB] == SEL_CODE) || grp_hit);

	// Protocol engine; START and STOP override any state.
	always_comb begin
		st_nxt     = st_r;
		cnt_nxt    = cnt_r;
		sh_nxt     = sh_r;
		oe_nxt     = oe_r;
		rw_nxt     = rw_r;
		first_nxt  = first_r;
		ptr_nxt    = ptr_r;
		wdata_nxt  = wdata_r;
		wr_stb_nxt = 1'b0;
		rd_stb_nxt = 1'b0;
		grp_nxt    = grp_r;
		if (start_ev) begin
			st_nxt    = DS_ADDR;
			cnt_nxt   = 4'h0;
			oe_nxt    = 1'b0;
			first_nxt = 1'b1;
		end else if (stop_ev) begin
			st_nxt = DS_IDLE;
			oe_nxt = 1'b0;
		end else begin
			unique case (st_r)
				DS_IDLE, DS_IGNORE: begin
					oe_nxt = 1'b0;
				end
				DS_ADDR, DS_RX: begin
					if (scl_rise && cnt_r != BIT_ACK) begin
						sh_nxt  = {sh_r[6:0], line_f[0]};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == BIT_ACK) begin
						cnt_nxt = 4'h0;
						if (st_r == DS_ADDR) begin
							if (match) begin
								oe_nxt  = 1'b1;
								rw_nxt  = sh_r[RW_BIT];
								grp_nxt = grp_hit;
								st_nxt  = DS_ACK;
							end else begin
								st_nxt = DS_IGNORE;
							end
						end else begin
							oe_nxt = 1'b1;
							st_nxt = DS_ACK;
							if (first_r) begin
								ptr_nxt   = sh_r;
								first_nxt = 1'b0;
							end else begin
								wdata_nxt  = sh_r;
								wr_stb_nxt = 1'b1;
							end
						end
					end
				end
				DS_ACK: begin
					// The acknowledge is held until the ninth pulse has ended.
					if (scl_fall) begin
						cnt_nxt = 4'h0;
						if (rw_r) begin
							sh_nxt     = rd_data_i;
							rd_stb_nxt = 1'b1;
							oe_nxt     = ~rd_data_i[7];
							st_nxt     = DS_TX;
						end else begin
							oe_nxt = 1'b0;
							st_nxt = DS_RX;
						end
					end
				end
				DS_TX: begin
					// Group reads drive all sensors at once; the wire ANDs them.
					if (scl_fall) begin
						cnt_nxt = cnt_r + 4'h1;
						if (cnt_r == BIT_LAST) begin
							oe_nxt = 1'b0;
							st_nxt = DS_TXACK;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = ~sh_r[6];
						end
					end
				end
				DS_TXACK: begin
					if (scl_rise) begin
						st_nxt = line_f[0] ? DS_IGNORE : DS_ACK;
					end
				end
			endcase
		end
	end

	// State registers; the pointer survives transfers until reset or a new pointer byte.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_r     <= DS_IDLE;
			cnt_r    <= 4'h0;
			sh_r     <= BYTE_ZERO;
			oe_r     <= 1'b0;
			rw_r     <= 1'b0;
			first_r  <= 1'b0;
			ptr_r    <= PTR_RESET;
			wdata_r  <= BYTE_ZERO;
			wr_stb_r <= 1'b0;
			rd_stb_r <= 1'b0;
			grp_r    <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			cnt_r    <= cnt_nxt;
			sh_r     <= sh_nxt;
			oe_r     <= oe_nxt;
			rw_r     <= rw_nxt;
			first_r  <= first_nxt;
			ptr_r    <= ptr_nxt;
			wdata_r  <= wdata_nxt;
			wr_stb_r <= wr_stb_nxt;
			rd_stb_r <= rd_stb_nxt;
			grp_r    <= grp_nxt;
		end
	end

	// The pad only ever pulls low, so its output value is a constant zero.
	assign bus.s_sda_out = 1'b0;
	assign bus.s_sda_oe  = oe_r;
	assign ptr_o         = ptr_r;
	assign wdata_o       = wdata_r;
	assign wr_stb_o      = wr_stb_r;
	assign rd_stb_o      = rd_stb_r;
	assign group_o       = grp_r;
endmodule

// File: hdl/tws_host.sv
`timescale 1ns/1ps
// Bus master: drives the clock from a divider and runs byte commands.
module tws_host
	import tws_pkg::*;
(
	input  wire logic     clock_i,
	input  wire logic     rst_i,
	tws_bus_if.host       bus,
	input  wire logic     cmd_valid_i,
	input  wire tws_cmd_t cmd_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic     nack_i,
	output logic          cmd_ready_o,
	output logic          done_o,
	output logic    [7:0] rdata_o,
	output logic          ack_rcvd_o
);
	typedef enum logic [3:0] {
		HS_IDLE, HS_HOLD, HS_ST_HD, HS_RS_A, HS_RS_B, HS_BL1, HS_BL2, HS_BH,
		HS_SP_A, HS_SP_B, HS_SP_C
	} tws_host_st_t;

	logic [1:0]   line_f;
	tws_host_st_t st_r;
	tws_host_st_t st_nxt;
	logic [7:0]   tmr_r;
	logic [7:0]   tmr_nxt;
	logic [3:0]   bit_r;
	logic [3:0]   bit_nxt;
	logic [8:0]   tx_r;
	logic [8:0]   tx_nxt;
	logic [8:0]   rx_r;
	logic [8:0]   rx_nxt;
	logic         scl_oe_r;
	logic         scl_oe_nxt;
	logic         sda_oe_r;
	logic         sda_oe_nxt;
	logic         done_r;
	logic         done_nxt;
	logic [7:0]   rdata_r;
	logic [7:0]   rdata_nxt;
	logic         ack_r;
	logic         ack_nxt;
	logic         take;

	tws_sync u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.line_i  ({bus.scl, bus.sda}),
		.line_o  (line_f)
	);

	// Commands are taken only with the bus idle or held with clock low.
	assign cmd_ready_o = (st_r == HS_IDLE) || (st_r == HS_HOLD);
	assign take        = cmd_valid_i && cmd_ready_o;

	// Each phase loads the timer and advances when it has run out.
	always_comb begin
		st_nxt     = st_r;
		tmr_nxt    = (tmr_r != 8'h00) ? tmr_r - 8'h01 : tmr_r;
		bit_nxt    = bit_r;
		tx_nxt     = tx_r;
		rx_nxt     = rx_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		done_nxt   = 1'b0;
		rdata_nxt  = rdata_r;
		ack_nxt    = ack_r;
		unique case (st_r)
			HS_IDLE: begin
				// Outside a transfer only START means anything.
				if (take && cmd_i == CMD_START) begin
					sda_oe_nxt = 1'b1;
					tmr_nxt    = CYC_HDSTA;
					st_nxt     = HS_ST_HD;
				end
			end
			HS_HOLD: begin
				if (take) begin
					bit_nxt = 4'h0;
					tmr_nxt = CYC_LOW_HALF;
					unique case (cmd_i)
						// The clock has been low only a few cycles here, so the
						// whole low period is timed before it is released.
						CMD_START: begin
							sda_oe_nxt = 1'b0;
							tmr_nxt    = 8'(CYC_LOW_HALF + CYC_LOW_HALF);
							st_nxt     = HS_RS_A;
						end
						CMD_STOP: begin
							sda_oe_nxt = 1'b1;
							tmr_nxt    = 8'(CYC_LOW_HALF + CYC_LOW_HALF);
							st_nxt     = HS_SP_A;
						end
						CMD_WRITE: begin
							tx_nxt = {wdata_i, 1'b1};
							st_nxt = HS_BL1;
						end
						CMD_READ: begin
							tx_nxt = {8'hff, nack_i};
							st_nxt = HS_BL1;
						end
					endcase
				end
			end
			HS_ST_HD: begin
				if (tmr_r == 8'h00) begin
					scl_oe_nxt = 1'b1;
					done_nxt   = 1'b1;
					st_nxt     = HS_HOLD;
				end
			end
			HS_RS_A: begin
				if (tmr_r == 8'h00) begin
					scl_oe_nxt = 1'b0;
					tmr_nxt    = CYC_SUSTA;
					st_nxt     = HS_RS_B;
				end
			end
			HS_RS_B: begin
				if (!line_f[1]) begin
					tmr_nxt = CYC_SUSTA;
				end else if (tmr_r == 8'h00) begin
					sda_oe_nxt = 1'b1;
					tmr_nxt    = CYC_HDSTA;
					st_nxt     = HS_ST_HD;
				end
			end
			HS_BL1: begin
				// Data changes mid-low, well after the falling clock edge.
				if (tmr_r == 8'h00) begin
					sda_oe_nxt = ~tx_r[8];
					tmr_nxt    = CYC_LOW_HALF;
					st_nxt     = HS_BL2;
				end
			end
			HS_BL2: begin
				if (tmr_r == 8'h00) begin
					scl_oe_nxt = 1'b0;
					tmr_nxt    = CYC_HIGH;
					st_nxt     = HS_BH;
				end
			end
			HS_BH: begin
				// High time counts from the observed rising level, not the release.
				if (!line_f[1]) begin
					tmr_nxt = CYC_HIGH;
				end else if (tmr_r == 8'h00) begin
					scl_oe_nxt = 1'b1;
					rx_nxt     = {rx_r[7:0], line_f[0]};
					tx_nxt     = {tx_r[7:0], 1'b1};
					bit_nxt    = bit_r + 4'h1;
					tmr_nxt    = CYC_LOW_HALF;
					st_nxt     = HS_BL1;
					if (bit_r == BIT_ACK) begin
						rdata_nxt = rx_r[7:0];
						ack_nxt   = ~line_f[0];
						done_nxt  = 1'b1;
						st_nxt    = HS_HOLD;
					end
				end
			end
			HS_SP_A: begin
				if (tmr_r == 8'h00) begin
					scl_oe_nxt = 1'b0;
					tmr_nxt    = CYC_SUSTO;
					st_nxt     = HS_SP_B;
				end
			end
			HS_SP_B: begin
				if (!line_f[1]) begin
					tmr_nxt = CYC_SUSTO;
				end else if (tmr_r == 8'h00) begin
					sda_oe_nxt = 1'b0;
					tmr_nxt    = CYC_BUF;
					st_nxt     = HS_SP_C;
				end
			end
			HS_SP_C: begin
				if (tmr_r == 8'h00) begin
					done_nxt = 1'b1;
					st_nxt   = HS_IDLE;
				end
			end
		endcase
	end

	// State registers; lines are released during reset.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_r     <= HS_IDLE;
			tmr_r    <= 8'h00;
			bit_r    <= 4'h0;
			tx_r     <= 9'h1ff;
			rx_r     <= 9'h000;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			done_r   <= 1'b0;
			rdata_r  <= BYTE_ZERO;
			ack_r    <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			tmr_r    <= tmr_nxt;
			bit_r    <= bit_nxt;
			tx_r     <= tx_nxt;
			rx_r     <= rx_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			done_r   <= done_nxt;
			rdata_r  <= rdata_nxt;
			ack_r    <= ack_nxt;
		end
	end

	assign bus.m_scl_out = 1'b0;
	assign bus.m_scl_oe  = scl_oe_r;
	assign bus.m_sda_out = 1'b0;
	assign bus.m_sda_oe  = sda_oe_r;
	assign done_o        = done_r;
	assign rdata_o       = rdata_r;
	assign ack_rcvd_o    = ack_r;
endmodule

// File: tb/tws_bus_properties.sv
`timescale 1ns/1ps
// Watches the wired lines; counters saturate so a long idle bus never wraps them.
module tws_bus_properties (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic m_scl_oe,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_r, sda_r, idle_r, idle_nxt, start_ev, stop_ev;
	logic [7:0] low_r, low_nxt, hi_r, hi_nxt, buf_r, buf_nxt;

	// Bus events and the length of the current clock phase and of the free time.
	always_comb begin
		start_ev = scl && scl_r && sda_r && !sda;
		stop_ev  = scl && scl_r && !sda_r && sda;
		low_nxt  = scl ? 8'h00 : low_r + 8'(low_r != 8'hff);
		hi_nxt   = !scl ? 8'h00 : hi_r + 8'(hi_r != 8'hff);
		buf_nxt  = stop_ev ? 8'h00 : buf_r + 8'(buf_r != 8'hff);
		idle_nxt = stop_ev ? 1'b1 : (start_ev ? 1'b0 : idle_r);
	end

	// Reset values treat the bus as long idle, so the first START is legal.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			scl_r  <= 1'b1;
			sda_r  <= 1'b1;
			idle_r <= 1'b1;
			low_r  <= 8'h00;
			hi_r   <= 8'hff;
			buf_r  <= 8'hff;
		end else begin
			scl_r  <= scl;
			sda_r  <= sda;
			idle_r <= idle_nxt;
			low_r  <= low_nxt;
			hi_r   <= hi_nxt;
			buf_r  <= buf_nxt;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_dev_hold; scl && scl_r |-> $stable(s_sda_oe); endproperty
	a_dev_hold: assert property (p_dev_hold) else $error("device data moved with clock high");
	property p_dev_setup; $rose(s_sda_oe) |-> !scl [*8]; endproperty
	a_dev_setup: assert property (p_dev_setup) else $error("device data too late");
	property p_scl_low; $rose(scl) |-> low_r >= 8'ha3; endproperty
	a_scl_low: assert property (p_scl_low) else $error("clock low too short");
	property p_hdsta; start_ev |-> scl [*8] ##1 scl [*5]; endproperty
	a_hdsta: assert property (p_hdsta) else $error("start hold too short");
	property p_susta; start_ev |-> hi_r >= 8'h0d; endproperty
	a_susta: assert property (p_susta) else $error("start setup too short");
	property p_susto; stop_ev |-> hi_r >= 8'h0d; endproperty
	a_susto: assert property (p_susto) else $error("stop setup too short");
	property p_tbuf; start_ev |-> buf_r >= 8'h4b; endproperty
	a_tbuf: assert property (p_tbuf) else $error("bus free time too short");
	property p_released; idle_r |-> !s_sda_oe; endproperty
	a_released: assert property (p_released) else $error("device drives idle bus");
	property p_idle_high; idle_r |-> scl && !m_scl_oe; endproperty
	a_idle_high: assert property (p_idle_high) else $error("clock not idle high");
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`define CHECK_EQ(nm, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("FAIL %s exp %0h got %0h", nm, e, g); \
	end \
end
// Host and three sensors share one wired bus; the bench drives only user sides.
module testbench;
	import tws_pkg::*;
	localparam logic [2:0] SELS [3] = '{SEL_VAR_A, SEL_VAR_B, SEL_VAR_C};
	logic       clock_i, rst_i, cmd_valid_i, nack_i, cmd_ready_o, done_o, ack_rcvd_o;
	tws_cmd_t   cmd_i;
	logic [7:0] wdata_i, rdata_o;
	logic [7:0] rd_byte [3], ptr_w [3], wd_w [3], exp_ptr [3], exp_wd [3];
	logic [2:0] oe, wstb, rstb, grp;
	int         err_total = 0, check_count = 0;
	int         wcnt [3] = '{default: 0}, rcnt [3] = '{default: 0};
	int         exp_wc [3] = '{default: 0}, exp_rc [3] = '{default: 0};

	tws_bus_if tws_bus_if_i ();
	// Each sensor's drive joins the shared data line as a wired AND.
	assign tws_bus_if_i.s_sda_out = 1'b0;
	assign tws_bus_if_i.s_sda_oe  = |oe;

	// A sensor gets its own copy of the bus whose host half mirrors the wired levels.
	for (genvar i = 0; i < 3; i++) begin : gd
		tws_bus_if dev_bus_i ();
		assign dev_bus_i.m_scl_out = 1'b0;
		assign dev_bus_i.m_sda_out = 1'b0;
		assign dev_bus_i.m_scl_oe  = tws_bus_if_i.m_scl_oe;
		assign dev_bus_i.m_sda_oe  = !tws_bus_if_i.sda;
		assign oe[i]               = dev_bus_i.s_sda_oe;
		tws_dev #(.SEL_CODE(SELS[i])) tws_dev_i (
			.clock_i  (clock_i),
			.rst_i    (rst_i),
			.bus      (dev_bus_i),
			.rd_data_i(rd_byte[i]),
			.ptr_o    (ptr_w[i]),
			.wdata_o  (wd_w[i]),
			.wr_stb_o (wstb[i]),
			.rd_stb_o (rstb[i]),
			.group_o  (grp[i])
		);
	end

	tws_host tws_host_i (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.bus        (tws_bus_if_i),
		.cmd_valid_i(cmd_valid_i),
		.cmd_i      (cmd_i),
		.wdata_i    (wdata_i),
		.nack_i     (nack_i),
		.cmd_ready_o(cmd_ready_o),
		.done_o     (done_o),
		.rdata_o    (rdata_o),
		.ack_rcvd_o (ack_rcvd_o)
	);

	tws_bus_properties tws_bus_properties_i (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.m_scl_oe(tws_bus_if_i.m_scl_oe),
		.s_sda_oe(tws_bus_if_i.s_sda_oe),
		.scl     (tws_bus_if_i.scl),
		.sda     (tws_bus_if_i.sda)
	);

	// Core clock of 8 ns.
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	// Strobes last one cycle, so counting at the falling edge sees each exactly once.
	always @(negedge clock_i) begin
		for (int j = 0; j < 3; j++) begin
			wcnt[j] += int'(wstb[j] === 1'b1);
			rcnt[j] += int'(rstb[j] === 1'b1);
		end
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	function automatic logic [7:0] adr(input logic [2:0] s, input logic rw);
		return {ADDR_FIXED, s, rw};
	endfunction

	// One command: raised at a falling edge, taken at the next rising edge, then done awaited.
	task automatic op(input tws_cmd_t c, input logic [7:0] d, input logic n);
		int k;
		@(negedge clock_i);
		for (k = 0; k < 9000 && cmd_ready_o !== 1'b1; k++) @(negedge clock_i);
		cmd_i = c;
		wdata_i = d;
		nack_i = n;
		cmd_valid_i = 1'b1;
		@(negedge clock_i);
		cmd_valid_i = 1'b0;
		for (k = 0; k < 9000 && done_o !== 1'b1; k++) @(negedge clock_i);
		if (k == 9000) begin
			err_total++;
			$display("FAIL done exp 1 got 0");
			give_verdict();
		end
	endtask

	// Reset wait covers the sensors' input filter before the first START.
	task automatic do_reset();
		@(negedge clock_i);
		rst_i = 1'b1;
		repeat (2) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (10) @(negedge clock_i);
		for (int j = 0; j < 3; j++) begin
			exp_ptr[j] = PTR_RESET;
			exp_wd[j] = BYTE_ZERO;
		end
	endtask

	task automatic verify();
		for (int j = 0; j < 3; j++) begin
			`CHECK_EQ("ptr", exp_ptr[j], ptr_w[j])
			`CHECK_EQ("wdata", exp_wd[j], wd_w[j])
			`CHECK_EQ("wr_stb", exp_wc[j], wcnt[j])
			`CHECK_EQ("rd_stb", exp_rc[j], rcnt[j])
		end
	endtask

	task automatic wr_txn(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
			input logic e);
		op(CMD_START, 8'h00, 1'b0);
		op(CMD_WRITE, a, 1'b0);
		`CHECK_EQ("addr_ack", e, ack_rcvd_o)
		op(CMD_WRITE, p, 1'b0);
		`CHECK_EQ("ptr_ack", e, ack_rcvd_o)
		op(CMD_WRITE, d, 1'b0);
		`CHECK_EQ("data_ack", e, ack_rcvd_o)
		op(CMD_STOP, 8'h00, 1'b0);
	endtask

	// The last byte read is answered with a not-acknowledge.
	task automatic rd_txn(input logic [7:0] a, input int n, input logic [7:0] x);
		op(CMD_START, 8'h00, 1'b0);
		op(CMD_WRITE, a, 1'b0);
		`CHECK_EQ("rd_addr_ack", 1'b1, ack_rcvd_o)
		for (int k = 1; k <= n; k++) begin
			op(CMD_READ, 8'h00, 1'(k == n));
			`CHECK_EQ("rd_byte", x, rdata_o)
		end
		op(CMD_STOP, 8'h00, 1'b0);
	endtask

	initial begin
		rst_i = 1'b1;
		cmd_valid_i = 1'b0;
		cmd_i = CMD_START;
		wdata_i = 8'h00;
		nack_i = 1'b0;
		rd_byte = '{8'hde, 8'hb6, 8'h7b};
		do_reset();
		verify();
		for (int j = 0; j < 3; j++) begin
			wr_txn(adr(SELS[j], 1'b0), 8'h50 + 8'(j), 8'ha1 + 8'(j), 1'b1);
			exp_ptr[j] = 8'h50 + 8'(j);
			exp_wd[j] = 8'ha1 + 8'(j);
			exp_wc[j]++;
			verify();
		end
		// Foreign select code, then a wrong fixed nibble differing only in the top bit.
		for (int f = 0; f < 2; f++) begin
			wr_txn(f ? {4'h6, SEL_VAR_A, 1'b0} : adr(3'h6, 1'b0), 8'h33, 8'h44, 1'b0);
			verify();
		end
		// Pointer only, then a repeated START into a read; a later read reuses the pointer.
		op(CMD_START, 8'h00, 1'b0);
		op(CMD_WRITE, adr(SELS[1], 1'b0), 1'b0);
		op(CMD_WRITE, 8'h07, 1'b0);
		`CHECK_EQ("ptr_only_ack", 1'b1, ack_rcvd_o)
		exp_ptr[1] = 8'h07;
		rd_txn(adr(SELS[1], 1'b1), 2, rd_byte[1]);
		rd_txn(adr(SELS[1], 1'b1), 1, rd_byte[1]);
		exp_rc[1] += 3;
		verify();
		`CHECK_EQ("no_group", 1'b0, grp[1])
		// All sensors answer the group code; a group read shows the AND of their bytes.
		wr_txn(adr(SEL_GROUP, 1'b0), 8'h22, 8'h99, 1'b1);
		rd_txn(adr(SEL_GROUP, 1'b1), 1, rd_byte[0] & rd_byte[1] & rd_byte[2]);
		for (int j = 0; j < 3; j++) begin
			exp_ptr[j] = 8'h22;
			exp_wd[j] = 8'h99;
			exp_wc[j]++;
			exp_rc[j]++;
		end
		verify();
		`CHECK_EQ("group", 3'h7, grp)
		do_reset();
		verify();
		give_verdict();
	end
endmodule
